// >>> hw/rswd_params.svh
// constants for the reset and watchdog block
`ifndef RSWD_PARAMS_SVH
`define RSWD_PARAMS_SVH
`define RSWD_CLK_HZ 25000000
`define RSWD_CLK_MHZ 25
`define RSWD_WDOSC_HZ 128000
`define RSWD_STARTUP_US 64
`define RSWD_DROP_MIN_NS 2000
`define RSWD_EXT_MIN_NS 2500
`define RSWD_UNLOCK_CYC 3'h4
`define RSWD_TO_BASE 22'h000800
`define RSWD_PER_MAX 4'h9
`define RSWD_A_FLAGS 2'h0
`define RSWD_A_CTL 2'h1
`define RSWD_A_ODD 2'h2
`define RSWD_F_POR 0
`define RSWD_F_EXT 1
`define RSWD_F_DROP 2
`define RSWD_F_DOG 3
`define RSWD_F_USB 5
`define RSWD_C_IRQF 7
`define RSWD_C_IRQEN 6
`define RSWD_C_PER3 5
`define RSWD_C_UNLOCK 4
`define RSWD_C_RSTEN 3
`define RSWD_O_EFLAG 2
`define RSWD_O_EEN 3
`endif

// >>> hw/rswd_pkg.sv
// types for the reset and watchdog block
package rswd_pkg;
	typedef enum logic [1:0] {
		RSWD_STOP = 2'b00,
		RSWD_IRQ = 2'b01,
		RSWD_RST = 2'b10,
		RSWD_BOTH = 2'b11
	} rswd_mode_t;
endpackage

// >>> hw/rswd_top.sv
// reset aggregation, start-up stretch and watchdog timer
`timescale 1ns/1ns
`include "rswd_params.svh"
// Function
// - five reset requests each reset the controller
// - long low on external pin resets even without clock
// - watchdog reset is a one-cycle pulse; delay starts after it
// - reset held until start-up delay expires after release
// - power-on request reasserts reset at once, no delay
// - enabled brown-out detector asserts reset when supply drops
// - brown-out shorter than minimum duration is ignored
// - USB bus reset resets processor, USB stays attached
// - watchdog counts ticks of a slow oscillator tick divided down from the clock
// - early warning interrupt at first time-out value
// - interrupt or reset at twice the time-out value
// - restart clears the counter; software restarts in time
// - combined mode: interrupt first, then next double time-out resets
// - always-on fuse forces reset-only mode
// - protected change only by one write within four cycles
// - prescaler periods from shortest to longest, even factors
// - odd divider on oscillator in series with prescaler
// - odd divider writable only while unlocked; reset enable stays
// - watchdog interrupt can wake from sleep
// - change unlock self-clears four cycles after set
// - reset enable reads one while dog reset flag set
// - each source sets its flag; write zero clears, power-on clears all but its own
// - combined mode vector entry clears flag and interrupt enable
module rswd_top #(
	parameter int STARTUP_CYCLES = `RSWD_STARTUP_US * `RSWD_CLK_MHZ,
	parameter int OSC_CYCLES = `RSWD_CLK_HZ / `RSWD_WDOSC_HZ,
	parameter logic [21:0] TO_BASE = `RSWD_TO_BASE
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_por_below,
	input wire logic i_ext_rst_b,
	input wire logic i_drop_below,
	input wire logic i_drop_det_en,
	input wire logic i_usb_en,
	input wire logic i_usb_rst_mcu_en,
	input wire logic i_usb_bus_rst,
	input wire logic i_always_on_fuse,
	input wire logic i_wdr,
	input wire logic i_irq_ack,
	output logic o_sys_rst,
	output logic o_wdt_irq,
	output logic o_wake,
	output rswd_pkg::rswd_mode_t o_wd_mode
);
	import rswd_pkg::*;

	localparam int DROP_CYC = (`RSWD_DROP_MIN_NS * `RSWD_CLK_MHZ + 999) / 1000;
	localparam int EXT_CYC = (`RSWD_EXT_MIN_NS * `RSWD_CLK_MHZ + 999) / 1000;
	localparam int OSC_DIV = OSC_CYCLES;
	localparam logic [15:0] STARTUP = 16'(STARTUP_CYCLES);
	localparam logic [7:0] DROP_MAX = 8'(DROP_CYC);
	localparam logic [7:0] EXT_MAX = 8'(EXT_CYC);
	localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);

	function automatic logic [21:0] timeout_of(input logic [3:0] per);
		logic [3:0] p;
		p = (per > `RSWD_PER_MAX) ? `RSWD_PER_MAX : per;
		timeout_of = TO_BASE << p;
	endfunction

	function automatic logic [2:0] odd_last(input logic [1:0] sel);
		odd_last = {sel, 1'b0};
	endfunction

	logic [7:0] ext_cnt_reg, ext_cnt_next;
	logic [7:0] drop_cnt_reg, drop_cnt_next;
	logic [15:0] dly_reg, dly_next;
	logic [5:0] flags_reg, flags_next;
	logic wd_pulse_reg;
	logic irq_flag_reg, irq_flag_next;
	logic irq_en_reg, irq_en_next;
	logic rst_en_reg, rst_en_next;
	logic [3:0] period_reg, period_next;
	logic [1:0] odd_sel_reg, odd_sel_next;
	logic early_en_reg, early_en_next;
	logic early_flag_reg, early_flag_next;
	logic [2:0] unlock_reg, unlock_next;
	logic [7:0] osc_cnt_reg;
	logic [2:0] odd_cnt_reg;
	logic [21:0] wd_cnt_reg, wd_cnt_next;
	logic [7:0] rdata_next;

	// reset sources
	wire ext_req = (ext_cnt_reg == EXT_MAX);
	wire drop_req = (drop_cnt_reg == DROP_MAX);
	wire usb_req = i_usb_en & i_usb_rst_mcu_en & i_usb_bus_rst;
	wire req_any = i_por_below | ext_req | drop_req | usb_req;
	wire int_rst = req_any | wd_pulse_reg | (dly_reg != 16'h0000);
	// raw pin and power-on terms bypass the clock so a stopped clock still resets
	assign o_sys_rst = int_rst | ~i_ext_rst_b;

	assign ext_cnt_next = i_ext_rst_b ? 8'h00 :
		(ext_req ? ext_cnt_reg : ext_cnt_reg + 8'h01);
	wire drop_low = i_drop_below & i_drop_det_en;
	assign drop_cnt_next = !drop_low ? 8'h00 :
		(drop_req ? drop_cnt_reg : drop_cnt_reg + 8'h01);
	// reload while any request or the watchdog pulse stands
	assign dly_next = (req_any | wd_pulse_reg) ? STARTUP :
		((dly_reg != 16'h0000) ? dly_reg - 16'h0001 : 16'h0000);

	// status flags, set beats write clear
	wire wr_flags = i_wr & (i_addr == `RSWD_A_FLAGS);
	wire [5:0] flag_keep = wr_flags ? (flags_reg & i_wdata[5:0]) : flags_reg;
	wire [5:0] flag_set = {usb_req, 1'b0, wd_pulse_reg, drop_req, ext_req, i_por_below};
	// power-on wipes the other flags; its own flag only by software
	wire [5:0] flag_por_mask = i_por_below ? 6'h01 : 6'h3F;
	assign flags_next = ((flag_keep & flag_por_mask) | flag_set) & 6'h2F;
	wire dog_flag = flags_reg[`RSWD_F_DOG];

	// control and timed sequence
	wire rst_en_eff = i_always_on_fuse | dog_flag | rst_en_reg;
	wire irq_en_eff = ~i_always_on_fuse & irq_en_reg;
	assign o_wd_mode = rswd_mode_t'({rst_en_eff, irq_en_eff});
	wire unlocked = (unlock_reg != 3'h0);
	wire wr_ctl = i_wr & (i_addr == `RSWD_A_CTL);
	wire wr_odd = i_wr & (i_addr == `RSWD_A_ODD);
	wire arm = wr_ctl & i_wdata[`RSWD_C_UNLOCK] & i_wdata[`RSWD_C_RSTEN];
	wire prot = wr_ctl & unlocked & ~i_wdata[`RSWD_C_UNLOCK];

	assign unlock_next = int_rst ? 3'h0 : arm ? `RSWD_UNLOCK_CYC :
		prot ? 3'h0 : (unlocked ? unlock_reg - 3'h1 : 3'h0);
	// a locked write may only raise the reset enable
	// the dog flag pins the enable so it survives clearing that flag
	assign rst_en_next = int_rst ? 1'b0 :
		dog_flag ? 1'b1 :
		prot ? i_wdata[`RSWD_C_RSTEN] :
		((wr_ctl & i_wdata[`RSWD_C_RSTEN]) | rst_en_reg);
	assign period_next = int_rst ? 4'h0 :
		prot ? {i_wdata[`RSWD_C_PER3], i_wdata[2:0]} : period_reg;
	// divider load keeps the unlock running, so a protected control write can follow
	assign odd_sel_next = int_rst ? 2'h0 :
		(wr_odd & unlocked) ? i_wdata[1:0] : odd_sel_reg;
	assign early_en_next = int_rst ? 1'b0 :
		wr_odd ? i_wdata[`RSWD_O_EEN] : early_en_reg;

	// clock-derived oscillator tick; the rate is approximate, a limitation
	wire osc_tick = (osc_cnt_reg == OSC_LAST);
	wire odd_end = (odd_cnt_reg == odd_last(odd_sel_reg));
	wire wd_tick = osc_tick & odd_end;
	wire running = rst_en_eff | irq_en_eff | early_en_reg;
	wire [21:0] to_val = timeout_of(period_reg);
	wire [21:0] to_dbl = {to_val[20:0], 1'b0};
	wire [21:0] cnt_inc = wd_cnt_reg + 22'h000001;
	wire early_hit = wd_tick & running & early_en_reg & (cnt_inc == to_val);
	wire dbl_hit = wd_tick & running & (cnt_inc == to_dbl);
	// pending flag in combined mode means the vector was missed
	wire fire_rst = dbl_hit & rst_en_eff & (~irq_en_eff | irq_flag_reg);
	wire fire_irq = dbl_hit & irq_en_eff & ~fire_rst;

	assign wd_cnt_next = (int_rst | i_wdr | ~running) ? 22'h000000 :
		(!wd_tick ? wd_cnt_reg : (dbl_hit ? 22'h000000 : cnt_inc));

	wire irq_clr = i_irq_ack | (wr_ctl & i_wdata[`RSWD_C_IRQF]);
	assign irq_flag_next = int_rst ? 1'b0 : fire_irq ? 1'b1 :
		(irq_clr ? 1'b0 : irq_flag_reg);
	wire combined = irq_en_eff & rst_en_eff;
	assign irq_en_next = int_rst ? 1'b0 :
		(i_irq_ack & combined) ? 1'b0 :
		(wr_ctl ? i_wdata[`RSWD_C_IRQEN] : irq_en_reg);
	wire eflag_clr = i_irq_ack | (wr_odd & i_wdata[`RSWD_O_EFLAG]);
	assign early_flag_next = int_rst ? 1'b0 : early_hit ? 1'b1 :
		(eflag_clr ? 1'b0 : early_flag_reg);

	// interrupt is a level that also serves as the wake request
	assign o_wdt_irq = (irq_flag_reg & irq_en_eff) | (early_flag_reg & early_en_reg);
	assign o_wake = o_wdt_irq;

	// register read, data valid only in the cycle after the strobe
	wire [7:0] rd_flags = {2'h0, flags_reg};
	wire [7:0] rd_ctl = {irq_flag_reg, irq_en_eff, period_reg[3], unlocked,
		rst_en_eff, period_reg[2:0]};
	wire [7:0] rd_odd = {4'h0, early_en_reg, early_flag_reg, odd_sel_reg};
	assign rdata_next = !i_rd ? 8'h00 :
		(i_addr == `RSWD_A_FLAGS) ? rd_flags :
		(i_addr == `RSWD_A_CTL) ? rd_ctl :
		(i_addr == `RSWD_A_ODD) ? rd_odd : 8'h00;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_cnt_reg <= 8'h00;
			drop_cnt_reg <= 8'h00;
			dly_reg <= STARTUP;
			flags_reg <= 6'h01;
			wd_pulse_reg <= 1'b0;
		end else begin
			ext_cnt_reg <= ext_cnt_next;
			drop_cnt_reg <= drop_cnt_next;
			dly_reg <= dly_next;
			flags_reg <= flags_next;
			wd_pulse_reg <= fire_rst;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_flag_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			rst_en_reg <= 1'b0;
			period_reg <= 4'h0;
			odd_sel_reg <= 2'h0;
			early_en_reg <= 1'b0;
			early_flag_reg <= 1'b0;
			unlock_reg <= 3'h0;
		end else begin
			irq_flag_reg <= irq_flag_next;
			irq_en_reg <= irq_en_next;
			rst_en_reg <= rst_en_next;
			period_reg <= period_next;
			odd_sel_reg <= odd_sel_next;
			early_en_reg <= early_en_next;
			early_flag_reg <= early_flag_next;
			unlock_reg <= unlock_next;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			osc_cnt_reg <= 8'h00;
			odd_cnt_reg <= 3'h0;
			wd_cnt_reg <= 22'h000000;
			o_rdata <= 8'h00;
		end else begin
			osc_cnt_reg <= osc_tick ? 8'h00 : osc_cnt_reg + 8'h01;
			if (osc_tick) begin
				odd_cnt_reg <= odd_end ? 3'h0 : odd_cnt_reg + 3'h1;
			end
			wd_cnt_reg <= wd_cnt_next;
			o_rdata <= rdata_next;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_arm_idle;
		arm ##1 (!arm && !prot && !int_rst) [*4];
	endsequence

	sequence s_dog_fire;
		fire_rst && !i_por_below ##1 wd_pulse_reg;
	endsequence

	a_pulse_one_cycle: assert property (wd_pulse_reg |=> !wd_pulse_reg)
		else $error("watchdog reset pulse longer than one cycle");
	a_delay_after_pulse: assert property ($fell(wd_pulse_reg) && !req_any
		|-> dly_reg == STARTUP && o_sys_rst)
		else $error("start-up delay not loaded after watchdog pulse");
	a_por_holds_delay: assert property (i_por_below |-> o_sys_rst ##1 dly_reg == STARTUP)
		else $error("power-on request did not hold reset");
	a_drop_filtered: assert property ($rose(drop_low) |-> !drop_req [*8])
		else $error("short supply drop caused a reset");
	a_unlock_expires: assert property (s_arm_idle |=> !unlocked)
		else $error("change unlock did not expire after four cycles");
	a_locked_period: assert property (wr_ctl && !unlocked && !int_rst |=> $stable(period_reg))
		else $error("period changed without unlock");
	a_dog_fire_flag: assert property (s_dog_fire |=> dog_flag && o_sys_rst)
		else $error("watchdog reset did not set its flag");
	a_fuse_mode: assert property (i_always_on_fuse |-> o_wd_mode == RSWD_RST)
		else $error("always-on fuse did not force reset mode");
	a_combined_ack: assert property (i_irq_ack && combined && !int_rst && !fire_irq
		|=> !irq_en_reg && !irq_flag_reg)
		else $error("vector entry did not leave combined mode");
	a_restart_clears: assert property (i_wdr |=> wd_cnt_reg == 22'h000000)
		else $error("restart did not clear the watchdog counter");
	a_usb_flag: assert property (usb_req && !i_por_below |-> o_sys_rst ##1 flags_reg[`RSWD_F_USB])
		else $error("bus reset did not reset and flag");
	a_dog_keeps_en: assert property (dog_flag |-> rd_ctl[`RSWD_C_RSTEN])
		else $error("reset enable reads zero while dog flag set");
	a_early_sets: assert property (early_hit && !int_rst |=> early_flag_reg)
		else $error("early warning flag not set at first time-out");
	a_dbl_irq_flag: assert property (fire_irq && !int_rst |=> irq_flag_reg)
		else $error("interrupt flag not set at double time-out");
	a_wake_irq: assert property (o_wdt_irq |-> o_wake)
		else $error("watchdog interrupt did not request wake");
	a_req_resets: assert property (req_any |-> o_sys_rst)
		else $error("reset request did not reset");
	a_pin_raw_rst: assert property (!i_ext_rst_b |-> o_sys_rst)
		else $error("low reset pin did not reset");
	a_drop_needs_en: assert property (!i_drop_det_en |=> !drop_req)
		else $error("disabled drop detector caused a reset");
	a_odd_locked: assert property (wr_odd && !unlocked && !int_rst |=> $stable(odd_sel_reg))
		else $error("odd divider changed without unlock");
	a_dog_pins_en: assert property (dog_flag && !int_rst |=> rst_en_reg)
		else $error("reset enable not held by dog flag");
	a_release_delay: assert property ($fell(req_any) && !wd_pulse_reg
		|-> dly_reg == STARTUP)
		else $error("start-up delay not loaded on release");
	a_arm_opens: assert property (arm && !int_rst |=> unlock_reg == `RSWD_UNLOCK_CYC)
		else $error("unlock did not open on arming write");
endmodule

// >>> test/rswd_det_model.sv
// analogue reset detectors and usb bus reset source for the bench
`timescale 1ns/1ns
module rswd_det_model (
	input wire logic i_clk,
	output logic o_por_below,
	output logic o_ext_rst_b,
	output logic o_drop_below,
	output logic o_usb_bus_rst
);
	logic [3:0] req = 4'h0;
	assign o_por_below = req[0];
	assign o_ext_rst_b = ~req[1];
	assign o_drop_below = req[2];
	assign o_usb_bus_rst = req[3];
	// one source at a time, so each flag has one cause
	task automatic pulse(input int sel, input int n);
		@(posedge i_clk);
		req[sel] <= 1'b1;
		repeat (n) @(posedge i_clk);
		req <= 4'h0;
	endtask
endmodule

// >>> test/tb.sv
// bench for the reset and watchdog block
`timescale 1ns/1ns
module tb;
	import rswd_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_drop_det_en = 1'b1;
	logic i_fuse = 1'b0;
	logic i_wdr = 1'b0;
	logic i_irq_ack = 1'b0;
	logic [7:0] o_rdata;
	logic o_sys_rst;
	logic o_wdt_irq;
	logic o_wake;
	rswd_mode_t o_wd_mode;
	logic por;
	logic ext_b;
	logic drop;
	logic usb;
	logic [7:0] v;
	int k;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	always #20 i_clk = ~i_clk;
	rswd_det_model det (.i_clk(i_clk), .o_por_below(por), .o_ext_rst_b(ext_b),
		.o_drop_below(drop), .o_usb_bus_rst(usb));
	// start-up count shortened so the stretch is measurable
	// short tick and time-out so the watchdog fires within the run
	rswd_top #(.STARTUP_CYCLES(20), .OSC_CYCLES(4), .TO_BASE(22'h000004)) uut (
		.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_por_below(por), .i_ext_rst_b(ext_b),
		.i_drop_below(drop), .i_drop_det_en(i_drop_det_en), .i_usb_en(1'b1),
		.i_usb_rst_mcu_en(1'b1), .i_usb_bus_rst(usb), .i_always_on_fuse(i_fuse),
		.i_wdr(i_wdr), .i_irq_ack(i_irq_ack), .o_sys_rst(o_sys_rst),
		.o_wdt_irq(o_wdt_irq), .o_wake(o_wake), .o_wd_mode(o_wd_mode));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// counts edges until internal reset lets go, bounded
	task automatic wait_rel(output int n);
		n = 0;
		while (o_sys_rst !== 1'b0 && n < 200) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk({7'h0, o_sys_rst}, 8'h00);
	endtask
	// waits for the interrupt (sel 0) or the reset (sel 1), bounded
	task automatic wait_hi(input int sel, input int lim, output int n);
		n = 0;
		while (((sel == 0) ? o_wdt_irq : o_sys_rst) !== 1'b1 && n < lim) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask
	task automatic kick();
		@(posedge i_clk);
		i_wdr <= 1'b1;
		@(posedge i_clk);
		i_wdr <= 1'b0;
	endtask
	task automatic src(input int sel, input int n, input logic [7:0] exp, input bit st);
		int m;
		fork
			det.pulse(sel, n);
			begin
				@(posedge i_clk);
				#1;
				if (sel < 2) chk({7'h0, o_sys_rst}, 8'h01);
			end
		join
		wait_rel(m);
		if (st) chk({7'h0, m >= 19 && m <= 24}, 8'h01);
		rd(2'h0, v);
		chk(v, exp);
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		wait_rel(k);
		chk({7'h0, k >= 19 && k <= 22}, 8'h01);
		rd(2'h0, v);
		chk(v, 8'h01);
		rd(2'h1, v);
		chk(v, 8'h00);
		wr(2'h3, 8'hFF);
		rd(2'h3, v);
		chk(v, 8'h00);
		wr(2'h0, 8'h00);
		rd(2'h0, v);
		chk(v, 8'h00);
		// flags pile up, nothing cleared until the partial write
		src(1, 70, 8'h02, 1);
		src(1, 10, 8'h02, 0);
		src(2, 60, 8'h06, 1);
		src(2, 30, 8'h06, 0);
		@(posedge i_clk);
		i_drop_det_en <= 1'b0;
		src(2, 60, 8'h06, 0);
		@(posedge i_clk);
		i_drop_det_en <= 1'b1;
		src(3, 5, 8'h26, 1);
		wr(2'h0, 8'hDF);
		rd(2'h0, v);
		chk(v, 8'h06);
		src(0, 5, 8'h01, 1);
		wr(2'h1, 8'h03);
		rd(2'h1, v);
		chk(v, 8'h00);
		wr(2'h1, 8'h18);
		wr(2'h1, 8'h27);
		rd(2'h1, v);
		chk(v, 8'h27);
		wr(2'h1, 8'h18);
		repeat (6) @(posedge i_clk);
		wr(2'h1, 8'h00);
		rd(2'h1, v);
		chk(v & 8'h18, 8'h08);
		wr(2'h2, 8'h03);
		rd(2'h2, v);
		chk(v, 8'h00);
		wr(2'h1, 8'h18);
		wr(2'h2, 8'h03);
		rd(2'h2, v);
		chk(v, 8'h03);
		rd(2'h1, v);
		chk(v & 8'h18, 8'h08);
		wr(2'h1, 8'h18);
		wr(2'h1, 8'h45);
		rd(2'h1, v);
		chk(v, 8'h45);
		chk({6'h0, o_wd_mode}, {6'h0, RSWD_IRQ});
		@(posedge i_clk);
		i_fuse <= 1'b1;
		rd(2'h1, v);
		chk(v & 8'h08, 8'h08);
		chk({6'h0, o_wd_mode}, {6'h0, RSWD_RST});
		@(posedge i_clk);
		i_fuse <= 1'b0;
		// reset mode with early warning: warning, then reset
		src(0, 5, 8'h01, 1);
		wr(2'h0, 8'h00);
		wr(2'h1, 8'h08);
		wr(2'h2, 8'h08);
		wait_hi(0, 60, k);
		chk({6'h0, o_wdt_irq, o_wake}, 8'h03);
		chk({7'h0, o_sys_rst}, 8'h00);
		rd(2'h2, v);
		chk(v, 8'h0C);
		wait_hi(1, 60, k);
		chk({7'h0, o_sys_rst}, 8'h01);
		wait_rel(k);
		chk({7'h0, k >= 19 && k <= 24}, 8'h01);
		kick();
		rd(2'h0, v);
		chk(v, 8'h08);
		wr(2'h0, 8'h00);
		rd(2'h1, v);
		chk(v, 8'h08);
		// combined mode: restarts hold it off, then interrupt, then reset
		wr(2'h1, 8'h48);
		rd(2'h1, v);
		chk(v, 8'h48);
		chk({6'h0, o_wd_mode}, {6'h0, RSWD_BOTH});
		repeat (5) begin
			kick();
			repeat (20) @(posedge i_clk);
		end
		#1;
		chk({6'h0, o_wdt_irq, o_sys_rst}, 8'h00);
		wait_hi(0, 60, k);
		chk({6'h0, o_wdt_irq, o_sys_rst}, 8'h02);
		@(posedge i_clk);
		i_irq_ack <= 1'b1;
		@(posedge i_clk);
		i_irq_ack <= 1'b0;
		rd(2'h1, v);
		chk(v, 8'h08);
		wait_hi(1, 60, k);
		chk({7'h0, o_sys_rst}, 8'h01);
		wait_rel(k);
		rd(2'h0, v);
		chk(v, 8'h08);
		finish_test();
	end
endmodule
